// >>> core/pldc_backoff.sv
// local bus back-off counter
`timescale 1ns/1ps
`default_nettype none
module pldc_backoff (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [2:0] code_in,
    input  wire logic       start_in,
    output logic            busy_out
);

    typedef struct packed {
        logic [10:0] cnt;
    } pldc_boff_t;

    pldc_boff_t s_r;
    pldc_boff_t s_nxt;

    // reserved codes give no wait rather than an unbounded one
    function automatic logic [10:0] wait_len(input logic [2:0] code);
        if (code == 3'h0 || code > pldc_pkg::BACKOFF_MAXCODE) begin
            return 11'h000;
        end
        return 11'(pldc_pkg::BACKOFF_UNIT << (code - 3'h1));
    endfunction

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_nxt = s_r;
        if (s_r.cnt != 11'h000) begin
            s_nxt.cnt = s_r.cnt - 11'h001;
        end
        if (start_in) begin
            s_nxt.cnt = wait_len(code_in);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy_out = (s_r.cnt != 11'h000);

endmodule
`default_nettype wire

// >>> core/pldc_dma_top.sv
// dma channel address, count and control core
`timescale 1ns/1ps
`default_nettype none
module pldc_dma_top (
    input  wire logic                   clk_sys_in,
    input  wire logic                   reset_n_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    input  wire logic [11:0]            reg_addr_in,
    input  wire logic [31:0]            reg_wdata_in,
    output logic      [31:0]            reg_rdata_out,
    input  wire logic                   go_in,
    input  wire logic                   chain_mode_in,
    input  wire logic                   dir_in,
    input  wire logic                   done_clear_in,
    input  wire logic                   burst_strap_in,
    input  wire logic                   local_byte_order_default_in,
    input  wire logic [7:0]             cache_line_size_field_in,
    input  wire logic [9:0]             fifo_bytes_in,
    input  wire logic                   xfer_busy_in,
    input  wire logic                   pci_word_in,
    input  wire logic                   local_word_in,
    input  wire logic                   pkt_valid_in,
    input  wire pldc_pkg::pldc_packet_t pkt_in,
    output logic                        active_out,
    output logic                        done_out,
    output logic                        halted_out,
    output logic                        start_refused_out,
    output logic                        pci_req_out,
    output logic                        local_req_out,
    output logic                        pkt_req_out,
    output logic                        packet_store_side_out,
    output logic      [31:0]            pci_addr_out,
    output logic      [31:0]            local_addr_out,
    output logic                        burst_enable_out,
    output logic                        full_burst_out,
    output logic      [8:0]             burst_limit_bytes_out,
    output logic      [1:0]             local_port_width_out,
    output logic                        byte_order_out,
    output logic      [3:0]             transaction_code_field_out
);

    //////////////////////////////////////////////////////////////////////////
    // reset release
    logic rst_meta_r;
    logic rst_sync_r;

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // helpers
    pldc_pkg::pldc_regs_t s_r;
    pldc_pkg::pldc_regs_t s_nxt;
    logic                 boff_busy;
    logic                 boff_start;
    logic                 running;
    logic [21:0]          pos_inc;
    logic [9:0]           thr_bytes;

    // keeps the top byte, so addresses never carry out of a 16 MB region
    function automatic logic [29:0] add_wrap24(input logic [29:0] a,
                                               input logic [21:0] inc);
        return {a[29:22], a[21:0] + inc};
    endfunction

    function automatic logic count_too_small(input logic [21:0] cnt);
        return {cnt, 2'b00} < pldc_pkg::MIN_COUNT_BYTES;
    endfunction

    function automatic pldc_pkg::pldc_ctl_t load_hi(
        input pldc_pkg::pldc_ctl_t c, input logic [31:0] w);
        pldc_pkg::pldc_ctl_t r;
        r           = c;
        r.tc        = w[pldc_pkg::CTL_TC_LSB +: 4];
        r.width     = w[pldc_pkg::CTL_WIDTH_LSB +: 2];
        r.flip      = w[pldc_pkg::CTL_FLIP_BIT];
        r.threshold = w[pldc_pkg::CTL_THR_LSB +: 4];
        return r;
    endfunction

    assign running  = (s_r.state == pldc_pkg::ST_RUN);
    assign pos_inc  = s_r.local_pos + 22'h000001;
    assign boff_start = running && local_word_in &&
        ((pos_inc[5:0] & (s_r.ctl.max_burst_sel ? pldc_pkg::WORDS_SML_MASK
                                                : pldc_pkg::WORDS_BIG_MASK))
         == 6'h00);

    // threshold, codes above eight clamp to 128 bytes
    always_comb begin
        if (s_r.ctl.threshold == 4'h0) begin
            thr_bytes = {cache_line_size_field_in, 2'b00};
        end else if (s_r.ctl.threshold > pldc_pkg::THR_MAX_CODE) begin
            thr_bytes = 10'(pldc_pkg::THR_MAX_CODE) *
                        pldc_pkg::THR_STEP_BYTES;
        end else begin
            thr_bytes = 10'(s_r.ctl.threshold) * pldc_pkg::THR_STEP_BYTES;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_nxt         = s_r;
        s_nxt.refused = 1'b0;
        if (!s_r.strap_taken) begin
            s_nxt.strap_taken = 1'b1;
            s_nxt.master_ok   = burst_strap_in;
        end
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                pldc_pkg::OFF_LOCAL_ADDR: s_nxt.rdata = {s_r.local_addr, 2'b00};
                pldc_pkg::OFF_PCI_ADDR: s_nxt.rdata = {s_r.pci_addr, 2'b00};
                pldc_pkg::OFF_COUNT: s_nxt.rdata = {8'h00, s_r.count, 2'b00};
                pldc_pkg::OFF_CTL: begin
                    s_nxt.rdata = 32'h0;
                    s_nxt.rdata[pldc_pkg::CTL_TC_LSB +: 4] = s_r.ctl.tc;
                    s_nxt.rdata[pldc_pkg::CTL_DIR_BIT] = dir_in;
                    s_nxt.rdata[pldc_pkg::CTL_WIDTH_LSB +: 2] = s_r.ctl.width;
                    s_nxt.rdata[pldc_pkg::CTL_FLIP_BIT] = s_r.ctl.flip;
                    s_nxt.rdata[pldc_pkg::CTL_THR_LSB +: 4] = s_r.ctl.threshold;
                    s_nxt.rdata[pldc_pkg::CTL_BOFF_LSB +: 3] = s_r.ctl.backoff;
                    s_nxt.rdata[pldc_pkg::CTL_FULL_BIT] = s_r.ctl.full_burst;
                    s_nxt.rdata[pldc_pkg::CTL_BURST_BIT] = s_r.ctl.burst_allow;
                    s_nxt.rdata[pldc_pkg::CTL_MAXB_BIT] = s_r.ctl.max_burst_sel;
                    s_nxt.rdata[pldc_pkg::CTL_SIDE_BIT] = s_r.ctl.packet_side;
                    s_nxt.rdata[pldc_pkg::CTL_STOP_BIT] = s_r.ctl.stop;
                    s_nxt.rdata[pldc_pkg::CTL_HALT_BIT] = s_r.halted;
                end
                default: s_nxt.rdata = 32'h0;
            endcase
        end
        if (done_clear_in) begin
            s_nxt.done = 1'b0;
        end
        unique case (s_r.state)
            pldc_pkg::ST_IDLE: begin
                if (go_in) begin
                    if (chain_mode_in) begin
                        s_nxt.state = pldc_pkg::ST_FETCH;
                    end else if (count_too_small(s_r.count)) begin
                        s_nxt.refused = 1'b1;
                    end else begin
                        s_nxt.state     = pldc_pkg::ST_RUN;
                        s_nxt.last      = 1'b1;
                        s_nxt.local_pos = 22'h0;
                    end
                end
            end
            pldc_pkg::ST_FETCH: begin
                if (pkt_valid_in) begin
                    s_nxt.local_addr = pkt_in.local_addr;
                    s_nxt.pci_addr   = pkt_in.pci_addr;
                    s_nxt.count      = {4'h0, pkt_in.count};
                    s_nxt.ctl        = load_hi(s_r.ctl, {pkt_in.ctl_hi, 20'h0});
                    s_nxt.last       = pkt_in.last;
                    s_nxt.local_pos  = 22'h0;
                    if (count_too_small({4'h0, pkt_in.count})) begin
                        s_nxt.state   = pldc_pkg::ST_IDLE;
                        s_nxt.refused = 1'b1;
                    end else begin
                        s_nxt.state = pldc_pkg::ST_RUN;
                    end
                end
            end
            pldc_pkg::ST_RUN: begin
                if (local_word_in) begin
                    s_nxt.local_pos = pos_inc;
                end
                if (pci_word_in) begin
                    s_nxt.pci_addr = add_wrap24(s_r.pci_addr, 22'h000001);
                    s_nxt.count = s_r.count - 22'h000001;
                end
                if (pci_word_in && s_r.count == 22'h000001) begin
                    if (chain_mode_in && !s_r.last) begin
                        s_nxt.state = pldc_pkg::ST_FETCH;
                    end else begin
                        s_nxt.state = pldc_pkg::ST_IDLE;
                        s_nxt.done  = 1'b1;
                    end
                // stop once the bus transfer ends
                end else if (s_r.ctl.stop && !xfer_busy_in) begin
                    s_nxt.state  = pldc_pkg::ST_HALT;
                    s_nxt.halted = 1'b1;
                end
            end
            pldc_pkg::ST_HALT: begin
                if (!s_r.ctl.stop) begin
                    s_nxt.state  = pldc_pkg::ST_RUN;
                    s_nxt.halted = 1'b0;
                end
            end
        endcase
        // either bus writes, software over hardware
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                pldc_pkg::OFF_LOCAL_ADDR: s_nxt.local_addr = reg_wdata_in[31:2];
                pldc_pkg::OFF_PCI_ADDR:   s_nxt.pci_addr = reg_wdata_in[31:2];
                pldc_pkg::OFF_COUNT:
                    s_nxt.count = reg_wdata_in[pldc_pkg::CNT_MSB:2];
                pldc_pkg::OFF_CTL: begin
                    s_nxt.ctl = load_hi(s_r.ctl, reg_wdata_in);
                    s_nxt.ctl.backoff =
                        reg_wdata_in[pldc_pkg::CTL_BOFF_LSB +: 3];
                    s_nxt.ctl.full_burst =
                        reg_wdata_in[pldc_pkg::CTL_FULL_BIT];
                    s_nxt.ctl.burst_allow =
                        reg_wdata_in[pldc_pkg::CTL_BURST_BIT];
                    s_nxt.ctl.max_burst_sel =
                        reg_wdata_in[pldc_pkg::CTL_MAXB_BIT];
                    s_nxt.ctl.packet_side =
                        reg_wdata_in[pldc_pkg::CTL_SIDE_BIT];
                    s_nxt.ctl.stop = reg_wdata_in[pldc_pkg::CTL_STOP_BIT];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            s_r            <= '0;
            s_r.state      <= pldc_pkg::ST_IDLE;
            s_r.pci_addr   <= pldc_pkg::ADDR_RST;
            s_r.local_addr <= pldc_pkg::ADDR_RST;
            s_r.count      <= pldc_pkg::COUNT_RST;
            s_r.ctl        <= pldc_pkg::CTL_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // back-off wait
    pldc_backoff u_backoff (
        .clk_in   (clk_sys_in),
        .rst_n_in (rst_sync_r),
        .code_in  (s_r.ctl.backoff),
        .start_in (boff_start),
        .busy_out (boff_busy)
    );

    //////////////////////////////////////////////////////////////////////////
    // outputs
    assign reg_rdata_out     = s_r.rdata;
    assign active_out        = (s_r.state != pldc_pkg::ST_IDLE);
    assign done_out          = s_r.done;
    assign halted_out        = s_r.halted;
    assign start_refused_out = s_r.refused;
    assign pci_req_out = running && !s_r.ctl.stop && fifo_bytes_in >= thr_bytes;
    assign local_req_out = running && !s_r.ctl.stop && !boff_busy;
    assign pkt_req_out           = (s_r.state == pldc_pkg::ST_FETCH);
    assign packet_store_side_out = s_r.ctl.packet_side;
    assign pci_addr_out = {s_r.pci_addr, 2'b00};
    // local address walks without touching the register
    assign local_addr_out = {add_wrap24(s_r.local_addr, s_r.local_pos), 2'b00};
    assign burst_enable_out = s_r.ctl.burst_allow && s_r.master_ok;
    assign full_burst_out = s_r.ctl.full_burst;
    assign burst_limit_bytes_out = s_r.ctl.max_burst_sel ?
        pldc_pkg::BURST_BYTES_SML : pldc_pkg::BURST_BYTES_BIG;
    // port width code passes straight out
    assign local_port_width_out = s_r.ctl.width;
    assign byte_order_out = local_byte_order_default_in ^ s_r.ctl.flip;
    assign transaction_code_field_out = active_out ? s_r.ctl.tc : 4'h0;

    //////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_sync_r);

    count_step_a: assert property (running && pci_word_in && !reg_wr_in &&
        s_r.count > 22'h000001 |=> s_r.count == $past(s_r.count) - 22'h1)
        else $error("count did not drop by one word");
    pci_wrap_a: assert property (running && pci_word_in && !reg_wr_in
        |=> s_r.pci_addr[29:22] == $past(s_r.pci_addr[29:22]))
        else $error("pci address left its region");
    local_hold_a: assert property (running && !reg_wr_in
        |=> s_r.local_addr == $past(s_r.local_addr))
        else $error("local address changed in run");
    refuse_a: assert property (s_r.state == pldc_pkg::ST_IDLE && go_in &&
        !chain_mode_in && count_too_small(s_r.count)
        |=> start_refused_out && !active_out)
        else $error("short count was started");
    dir_read_a: assert property (reg_rd_in && reg_addr_in == pldc_pkg::OFF_CTL
        |=> reg_rdata_out[pldc_pkg::CTL_DIR_BIT] == $past(dir_in))
        else $error("direction mirror wrong");
    halt_a: assert property ($rose(halted_out)
        |-> $past(s_r.ctl.stop) && !$past(xfer_busy_in))
        else $error("halted without stop or while busy");
    done_a: assert property (running && pci_word_in && !chain_mode_in &&
        s_r.count == 22'h000001 |=> done_out && !active_out)
        else $error("count end did not finish");
    backoff_a: assert property (boff_start && s_r.ctl.backoff == 3'h1
        |=> !local_req_out [*8])
        else $error("local request during back-off");
    burst_a: assert property (burst_enable_out |-> s_r.master_ok &&
        s_r.ctl.burst_allow)
        else $error("burst without strap or enable");
    pkt_count_a: assert property (s_r.state == pldc_pkg::ST_FETCH &&
        pkt_valid_in && !reg_wr_in |=> s_r.count[21:18] == 4'h0)
        else $error("packet count exceeded 1 MB");
    order_a: assert property (byte_order_out !=
        (local_byte_order_default_in == s_r.ctl.flip))
        else $error("byte order flip wrong");

    run_done_c: cover property (running ##[1:200] done_out);
    halt_c: cover property ($rose(halted_out) ##[1:50] !halted_out);
    chain_c: cover property (pkt_req_out ##1 pkt_valid_in);
    boff_c: cover property (boff_start ##1 !local_req_out);

endmodule
`default_nettype wire

// >>> core/pldc_pkg.sv
// package: register map, field layout, states and carriers of the dma channel
package pldc_pkg;

    //////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [11:0] OFF_LOCAL_ADDR = 12'h400;
    localparam logic [11:0] OFF_PCI_ADDR   = 12'h404;
    localparam logic [11:0] OFF_COUNT      = 12'h408;
    localparam logic [11:0] OFF_CTL        = 12'h410;

    //////////////////////////////////////////////////////////////////////////
    // control and count register field positions
    localparam int CTL_TC_LSB     = 28;
    localparam int CTL_DIR_BIT    = 27;
    localparam int CTL_WIDTH_LSB  = 25;
    localparam int CTL_FLIP_BIT   = 24;
    localparam int CTL_THR_LSB    = 20;
    localparam int CTL_BOFF_LSB   = 16;
    localparam int CTL_FULL_BIT   = 15;
    localparam int CTL_BURST_BIT  = 14;
    localparam int CTL_MAXB_BIT   = 9;
    localparam int CTL_SIDE_BIT   = 8;
    localparam int CTL_STOP_BIT   = 7;
    localparam int CTL_HALT_BIT   = 6;
    localparam int CNT_MSB        = 23;

    //////////////////////////////////////////////////////////////////////////
    // reset values and limits
    localparam logic [29:0] ADDR_RST        = 30'h0;
    localparam logic [21:0] COUNT_RST       = 22'h0;
    localparam logic [23:0] MIN_COUNT_BYTES = 24'h000010;
    localparam logic [3:0]  THR_MAX_CODE    = 4'h8;
    localparam logic [9:0]  THR_STEP_BYTES  = 10'h010;
    localparam logic [8:0]  BURST_BYTES_BIG = 9'h100;
    localparam logic [8:0]  BURST_BYTES_SML = 9'h040;
    localparam logic [5:0]  WORDS_BIG_MASK  = 6'h3f;
    localparam logic [5:0]  WORDS_SML_MASK  = 6'h0f;
    localparam logic [10:0] BACKOFF_UNIT    = 11'h040;
    localparam logic [2:0]  BACKOFF_MAXCODE = 3'h5;

    //////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_FETCH = 4'h2,
        ST_RUN   = 4'h4,
        ST_HALT  = 4'h8
    } pldc_state_t;

    typedef struct packed {
        logic [3:0] tc;
        logic [1:0] width;
        logic       flip;
        logic [3:0] threshold;
        logic [2:0] backoff;
        logic       full_burst;
        logic       burst_allow;
        logic       max_burst_sel;
        logic       packet_side;
        logic       stop;
    } pldc_ctl_t;

    localparam pldc_ctl_t CTL_RST = '0;

    typedef struct packed {
        logic [29:0] local_addr;
        logic [29:0] pci_addr;
        logic [17:0] count;
        logic [11:0] ctl_hi;
        logic        last;
    } pldc_packet_t;

    typedef struct packed {
        pldc_state_t state;
        logic [29:0] pci_addr;
        logic [29:0] local_addr;
        logic [21:0] count;
        logic [21:0] local_pos;
        pldc_ctl_t   ctl;
        logic        last;
        logic        halted;
        logic        done;
        logic        refused;
        logic        master_ok;
        logic        strap_taken;
        logic [31:0] rdata;
    } pldc_regs_t;

endpackage

// >>> dv/pci_local_bus_dma_channel_bench.sv
// testbench of the dma channel core
`timescale 1ns/1ps
`default_nettype none
module pci_local_bus_dma_channel_bench;
    logic        clk_sys_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        wr = 1'b0, rd = 1'b0, go = 1'b0, dir = 1'b0;
    logic        chain = 1'b0, dclr = 1'b0, busy = 1'b0;
    logic [31:0] paddr_o, laddr_o;
    logic [8:0]  blim;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic        word, pvalid, active, done, halted, refused, preq, kreq;
    logic [3:0]  tcode;
    logic [1:0]  width;
    logic        border, seen;
    int          error_cnt = 0, n_checks = 0;
    pldc_pkg::pldc_packet_t pkt = '0;
    always #5 clk_sys_in = ~clk_sys_in;
    pldc_dma_top dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .go_in(go),
        .chain_mode_in(chain), .dir_in(dir), .done_clear_in(dclr),
        .burst_strap_in(1'b0), .local_byte_order_default_in(1'b0),
        .cache_line_size_field_in(8'h00), .fifo_bytes_in(10'h3ff),
        .xfer_busy_in(busy), .pci_word_in(word), .local_word_in(word),
        .pkt_valid_in(pvalid), .pkt_in(pkt), .active_out(active),
        .done_out(done), .halted_out(halted), .start_refused_out(refused),
        .pci_req_out(preq), .local_req_out(), .pkt_req_out(kreq),
        .packet_store_side_out(), .pci_addr_out(paddr_o),
        .local_addr_out(laddr_o), .burst_enable_out(), .full_burst_out(),
        .burst_limit_bytes_out(blim),
        .local_port_width_out(width), .byte_order_out(border),
        .transaction_code_field_out(tcode));
    pldc_far_model far (.clk_in(clk_sys_in), .pci_req_in(preq),
        .pkt_req_in(kreq), .word_out(word), .pkt_valid_out(pvalid));
    ////////////////////////////////////////////////////////////////////////
    task tick; @(posedge clk_sys_in); #1; endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task wreg(input logic [11:0] a, input logic [31:0] d);
        addr = a; wdata = d; wr = 1'b1; tick; wr = 1'b0; tick;
    endtask
    task rreg(input logic [11:0] a, input logic [31:0] e, input string n);
        addr = a; rd = 1'b1; tick; rd = 1'b0; tick; chk(n, e, rdata);
    endtask
    task t_regs;
        rreg(12'h400, 32'h0, "laddr rst");
        rreg(12'h404, 32'h0, "paddr rst");
        rreg(12'h410, 32'h0, "ctl rst");
        wreg(12'h40c, 32'hffffffff);
        rreg(12'h40c, 32'h0, "unmapped");
        wreg(12'h404, 32'hffffffff);
        rreg(12'h404, 32'hfffffffc, "paddr");
        wreg(12'h408, 32'hffffffff);
        rreg(12'h408, 32'h00fffffc, "count");
        $display("test regs done");
    endtask
    task t_refuse;
        wreg(12'h408, 32'h0000000c);
        go = 1'b1; tick; seen = refused; go = 1'b0;
        tick; seen |= refused; tick; seen |= refused;
        chk("refused", 1, seen);
        chk("idle", 0, active);
        $display("test refuse done");
    endtask
    task t_run;
        wreg(12'h404, 32'h12fffff8);
        wreg(12'h400, 32'h00000100);
        wreg(12'h408, 32'h00000010);
        go = 1'b1; tick; go = 1'b0;
        for (int i = 0; i < 100 && done !== 1'b1; i++) tick;
        chk("done", 1, done);
        chk("active", 0, active);
        rreg(12'h404, 32'h12000008, "wrap");
        rreg(12'h408, 32'h0, "count end");
        rreg(12'h400, 32'h00000100, "laddr");
        chk("paddr out", 32'h12000008, paddr_o);
        chk("laddr out", 32'h00000110, laddr_o);
        $display("test run done");
    endtask
    task t_stop;
        dir = 1'b1; busy = 1'b1; dclr = 1'b1; tick; dclr = 1'b0;
        chk("done clr", 0, done);
        wreg(12'h408, 32'h00000040);
        go = 1'b1; tick; go = 1'b0;
        wreg(12'h410, 32'ha5000080);
        tick; tick;
        chk("busy hold", 0, halted);
        busy = 1'b0;
        for (int i = 0; i < 20 && halted !== 1'b1; i++) tick;
        chk("halted", 1, halted);
        chk("tc", 4'ha, tcode);
        chk("width", 2'b10, width);
        chk("order", 1, border);
        chk("burst cap", 9'h100, blim);
        rreg(12'h410, 32'had0000c0, "ctl");
        wreg(12'h410, 32'ha5000000);
        for (int i = 0; i < 200 && active !== 1'b0; i++) tick;
        chk("resumed", 0, halted);
        chk("ended", 0, active);
        chk("done", 1, done);
        $display("test stop done");
    endtask
    task t_chain;
        pkt = '{30'h10, 30'h41, 18'h4, 12'h300, 1'b1};
        dclr = 1'b1; chain = 1'b1; tick; dclr = 1'b0;
        go = 1'b1; tick; go = 1'b0;
        for (int i = 0; i < 100 && done !== 1'b1; i++) tick;
        chain = 1'b0;
        chk("chain done", 1, done);
        rreg(12'h404, 32'h00000114, "pkt paddr");
        rreg(12'h400, 32'h00000040, "pkt laddr");
        rreg(12'h408, 32'h0, "pkt count");
        rreg(12'h410, 32'h38000000, "pkt ctl");
        $display("test chain done");
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_sys_in);
        #1 reset_n_in = 1'b1;
        repeat (3) tick;
        t_regs;
        t_refuse;
        t_run;
        t_stop;
        t_chain;
        complete_run;
    end
    // run needs about 150 clocks; cut off far beyond that
    initial begin
        #20000;
        error_cnt++;
        complete_run;
    end
endmodule
`default_nettype wire

// >>> dv/pldc_far_model.sv
// far side model: pci agent and packet memory facing the channel
`timescale 1ns/1ps
`default_nettype none
module pldc_far_model (
    input  wire logic clk_in,
    input  wire logic pci_req_in,
    input  wire logic pkt_req_in,
    output logic      word_out,
    output logic      pkt_valid_out
);
    initial begin
        word_out = 1'b0;
        pkt_valid_out = 1'b0;
    end
    // one word every other clock while asked
    always @(posedge clk_in) begin
        word_out <= pci_req_in & ~word_out;
        // packet answered the clock after it is asked, whatever the store side
        pkt_valid_out <= pkt_req_in & ~pkt_valid_out;
    end
endmodule
`default_nettype wire
